// *** verilog/dfc_cfg.svh ***
// Purpose: Offsets, field positions and reset values of the function-control block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef DFC_CFG_SVH
`define DFC_CFG_SVH

// ==========================================================
// Register offsets
`define DFC_OFF_FUNC_CTRL   12'h000
`define DFC_OFF_UTIL        12'h004
`define DFC_OFF_IRQ_STATUS  12'h008
`define DFC_OFF_IRQ_MASK    12'h00c
`define DFC_OFF_STATUS      12'h010

// ==========================================================
// Function-control fields
`define DFC_BIT_RD_POISON_RPT   31
`define DFC_BIT_WR_POISON_RPT   30
`define DFC_BIT_IGN_MGR_POISON  29
`define DFC_BIT_RD_CHUNK_DIS    28
`define DFC_BIT_STRICT_ASSOC    25
`define DFC_BIT_RES_WAIT_CMD    19
`define DFC_BIT_PWR_REFUSE      18
`define DFC_BIT_NO_CACHE_CORR   17
`define DFC_BIT_RES_WAIT_SEARCH 16
`define DFC_CGO_MSB             10
`define DFC_FCTL_WMASK          32'hf20f07ff
`define DFC_FCTL_RESET          32'h00000000
`define DFC_UTIL_RESET          32'h00000000

// ==========================================================
// Interrupt status bits
`define DFC_IRQ_RD_POISON   0
`define DFC_IRQ_WR_REJECT   1
`define DFC_IRQ_PWR_DENY    2
`define DFC_IRQ_W           3

// ==========================================================
// Cache attribute values
`define DFC_CACHE_CORRECTED 4'hf
`define DFC_CACHE_IDX       4'h3

`endif

// *** verilog/dfc_pkg.sv ***
// Purpose: Shared types of the function-control block
// Assumes: Constants live in dfc_cfg.svh
// Notes:   Types only
package dfc_pkg;
    typedef enum logic [1:0] {
        DFC_Q_RUN,
        DFC_Q_ACCEPT,
        DFC_Q_DENY
    } dfc_qstate_t;
endpackage

// *** verilog/dfc_qchan.sv ***
// Purpose: Q-Channel power-down handshake with a software refuse override
// Assumes: qreq_n comes from another domain and is synchronised here
// Notes:   Accepts only when the block is idle
`include "dfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dfc_qchan
    import dfc_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic refuse,
    input  wire logic idle,
    // Q-Channel
    input  wire logic qreq_n,
    output logic      qaccept_n,
    output logic      power_request_refuse,
    output logic      qactive,
    output logic      deny_evt
);
    // ==========================================================
    // Synchroniser
    logic        sync1_r;
    logic        sync2_r;
    dfc_qstate_t st_r;
    dfc_qstate_t st_nxt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            st_r    <= DFC_Q_RUN;
        end else begin
            sync1_r <= qreq_n;
            sync2_r <= sync1_r;
            st_r    <= st_nxt;
        end
    end

    // ==========================================================
    // Handshake
    always_comb begin
        st_nxt   = st_r;
        deny_evt = 1'b0;
        case (st_r)
            DFC_Q_RUN: begin
                if (!sync2_r) begin
                    // Refuse beats idle so software can pin the block awake
                    if (refuse || !idle) begin
                        st_nxt   = DFC_Q_DENY;
                        deny_evt = 1'b1;
                    end else begin
                        st_nxt = DFC_Q_ACCEPT;
                    end
                end
            end
            DFC_Q_ACCEPT: if (sync2_r) st_nxt = DFC_Q_RUN;
            DFC_Q_DENY:   if (sync2_r) st_nxt = DFC_Q_RUN;
            default:      st_nxt = DFC_Q_RUN;
        endcase
    end

    assign qaccept_n = (st_r != DFC_Q_ACCEPT);
    assign power_request_refuse     = (st_r == DFC_Q_DENY);
    assign qactive   = !idle;

    property p_refuse_never_accepts;
        @(posedge pclk) disable iff (!presetn)
        (st_r == DFC_Q_RUN && !sync2_r && refuse) |=> power_request_refuse && qaccept_n;
    endproperty
    a_refuse_never_accepts: assert property (p_refuse_never_accepts)
        else $error("Power request accepted while refuse set");
endmodule // dfc_qchan
`default_nettype wire

// *** verilog/dfc_poison.sv ***
// Purpose: Poison reporting and write rejection for RAM, manager and subordinate paths
// Assumes: All inputs are on pclk
// Notes:   Outputs registered
`include "dfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dfc_poison (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Controls
    input  wire logic rd_report_en,
    input  wire logic wr_report_en,
    input  wire logic ignore_mgr,
    // Internal RAM reads
    input  wire logic ram_rd_valid,
    input  wire logic ram_rd_corrupt,
    // Subordinate writes
    input  wire logic sub_wr_valid,
    input  wire logic sub_wr_poison,
    // Manager read data
    input  wire logic mgr_rd_valid,
    input  wire logic mgr_rd_poison,
    // Results
    output logic      rd_poison_flag,
    output logic      sub_wr_reject,
    output logic      mgr_rd_error,
    output logic      rd_evt,
    output logic      wr_evt
);
    logic rd_r, rd_nxt;
    logic rej_r, rej_nxt;
    logic mge_r, mge_nxt;

    always_comb begin
        rd_nxt  = rd_report_en && ram_rd_valid && ram_rd_corrupt;
        rej_nxt = wr_report_en && sub_wr_valid && sub_wr_poison;
        mge_nxt = !ignore_mgr && mgr_rd_valid && mgr_rd_poison;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_r  <= 1'b0;
            rej_r <= 1'b0;
            mge_r <= 1'b0;
        end else begin
            rd_r  <= rd_nxt;
            rej_r <= rej_nxt;
            mge_r <= mge_nxt;
        end
    end

    assign rd_poison_flag = rd_r;
    assign sub_wr_reject  = rej_r;
    assign mgr_rd_error   = mge_r;
    assign rd_evt         = rd_r;
    assign wr_evt         = rej_r;

    property p_reject_poison;
        @(posedge pclk) disable iff (!presetn)
        (wr_report_en && sub_wr_valid && sub_wr_poison) |=> sub_wr_reject;
    endproperty
    a_reject_poison: assert property (p_reject_poison)
        else $error("Poisoned write not rejected");

    property p_read_poison;
        @(posedge pclk) disable iff (!presetn)
        (ram_rd_valid && ram_rd_corrupt) |=> (rd_poison_flag == $past(rd_report_en));
    endproperty
    a_read_poison: assert property (p_read_poison)
        else $error("Read poison report wrong");

    property p_ignore_mgr;
        @(posedge pclk) disable iff (!presetn)
        ignore_mgr |=> !mgr_rd_error;
    endproperty
    a_ignore_mgr: assert property (p_ignore_mgr)
        else $error("Manager poison not ignored");
endmodule // dfc_poison
`default_nettype wire

// *** verilog/dfc_top.sv ***
// Purpose: Distributor function-control register bank over APB and its control outputs
// Assumes: Single pclk domain; pprot[1] low marks a Secure access
// Notes:   Local chip only; nothing here is forwarded to remote chips
//
// Implementation choices: the placing of the registers and register access over APB.
`include "dfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dfc_top
    import dfc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [2:0]  pprot,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Poison paths
    input  wire logic        ram_rd_valid,
    input  wire logic        ram_rd_corrupt,
    input  wire logic        sub_wr_valid,
    input  wire logic        sub_wr_poison,
    input  wire logic        mgr_rd_valid,
    input  wire logic        mgr_rd_poison,
    output logic             read_poison_flag,
    output logic             sub_wr_reject,
    output logic             mgr_rd_error,
    // Q-Channel
    input  wire logic        qreq_n,
    input  wire logic        block_idle,
    output logic             qaccept_n,
    output logic             power_request_refuse,
    output logic             qactive,
    // Residency handshakes
    input  wire logic        res_cmd_done,
    input  wire logic        pt_search_done,
    output logic             res_proceed,
    // Controls to the distributor
    output logic             read_chunk_disable,
    output logic             strict_cache_assoc,
    output logic      [3:0]  mgr_cache_attr,
    output logic      [10:0] clock_run,
    output logic      [31:0] cache_utilization_control
);
    // ==========================================================
    // Helpers
    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction

    // ==========================================================
    // State
    logic [31:0]          fctl_r, fctl_nxt;
    logic [31:0]          util_r, util_nxt;
    logic [`DFC_IRQ_W-1:0] ist_r, ist_nxt;
    logic [`DFC_IRQ_W-1:0] imask_r, imask_nxt;
    logic [31:0]          rdata_r, rdata_nxt;
    logic                 err_r, err_nxt;
    logic                 rd_evt, wr_evt, deny_evt;
    logic                 wr_acc, rd_acc, secure, acc_wait_r;

    // Writes and the read-clear act only at the edge that completes the access
    assign wr_acc = psel && penable && acc_wait_r && pwrite;
    assign rd_acc = psel && penable && acc_wait_r && !pwrite;
    assign secure = !pprot[1];

    // ==========================================================
    // Submodules
    dfc_poison u_poison (
        .pclk           (pclk),
        .presetn        (presetn),
        .rd_report_en   (fctl_r[`DFC_BIT_RD_POISON_RPT]),
        .wr_report_en   (fctl_r[`DFC_BIT_WR_POISON_RPT]),
        .ignore_mgr     (fctl_r[`DFC_BIT_IGN_MGR_POISON]),
        .ram_rd_valid   (ram_rd_valid),
        .ram_rd_corrupt (ram_rd_corrupt),
        .sub_wr_valid   (sub_wr_valid),
        .sub_wr_poison  (sub_wr_poison),
        .mgr_rd_valid   (mgr_rd_valid),
        .mgr_rd_poison  (mgr_rd_poison),
        .rd_poison_flag (read_poison_flag),
        .sub_wr_reject  (sub_wr_reject),
        .mgr_rd_error   (mgr_rd_error),
        .rd_evt         (rd_evt),
        .wr_evt         (wr_evt)
    );

    dfc_qchan u_qchan (
        .pclk      (pclk),
        .presetn   (presetn),
        .refuse    (fctl_r[`DFC_BIT_PWR_REFUSE]),
        .idle      (block_idle),
        .qreq_n    (qreq_n),
        .qaccept_n (qaccept_n),
        .power_request_refuse     (power_request_refuse),
        .qactive   (qactive),
        .deny_evt  (deny_evt)
    );

    // ==========================================================
    // Register writes and reads
    always_comb begin
        fctl_nxt  = fctl_r;
        util_nxt  = util_r;
        imask_nxt = imask_r;
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b0;
        // Set wins over a read-clear in the same cycle
        ist_nxt   = ist_r;
        // Clear only the bits the read returned; an event after the sample survives
        if (rd_acc && paddr == `DFC_OFF_IRQ_STATUS) begin
            ist_nxt = ist_r & ~rdata_r[`DFC_IRQ_W-1:0];
        end
        ist_nxt[`DFC_IRQ_RD_POISON] = ist_nxt[`DFC_IRQ_RD_POISON] | rd_evt;
        ist_nxt[`DFC_IRQ_WR_REJECT] = ist_nxt[`DFC_IRQ_WR_REJECT] | wr_evt;
        ist_nxt[`DFC_IRQ_PWR_DENY]  = ist_nxt[`DFC_IRQ_PWR_DENY] | deny_evt;
        case (paddr)
            `DFC_OFF_FUNC_CTRL: begin
                // Non-secure writes are dropped and flagged; reads return zero
                if (!secure) begin
                    err_nxt = 1'b1;
                end else if (wr_acc) begin
                    fctl_nxt = apply_strb(fctl_r, pwdata, pstrb) & `DFC_FCTL_WMASK;
                end else begin
                    rdata_nxt = fctl_r;
                end
            end
            `DFC_OFF_UTIL: begin
                // Any security state may reach this one
                if (wr_acc) util_nxt = apply_strb(util_r, pwdata, pstrb);
                rdata_nxt = util_r;
            end
            `DFC_OFF_IRQ_STATUS: rdata_nxt = {{(32-`DFC_IRQ_W){1'b0}}, ist_r};
            `DFC_OFF_IRQ_MASK: begin
                if (wr_acc) imask_nxt = pwdata[`DFC_IRQ_W-1:0];
                rdata_nxt = {{(32-`DFC_IRQ_W){1'b0}}, imask_r};
            end
            `DFC_OFF_STATUS: rdata_nxt = {29'h0, power_request_refuse, !qaccept_n, res_proceed};
            default: begin
                err_nxt = 1'b1;
            end
        endcase
        if (!(psel && penable)) begin
            rdata_nxt = prdata;
            err_nxt   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fctl_r  <= `DFC_FCTL_RESET;
            util_r  <= `DFC_UTIL_RESET;
            ist_r   <= '0;
            imask_r <= '0;
            rdata_r <= 32'h00000000;
            err_r   <= 1'b0;
        end else begin
            fctl_r  <= fctl_nxt;
            util_r  <= util_nxt;
            ist_r   <= ist_nxt;
            imask_r <= imask_nxt;
            rdata_r <= rdata_nxt;
            err_r   <= err_nxt;
        end
    end

    // Read data is registered, so every access waits one cycle in its access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) acc_wait_r <= 1'b0;
        else          acc_wait_r <= psel && penable && !acc_wait_r;
    end

    // ==========================================================
    // Outputs
    // Registers only ever leave this block as local controls; no remote copy exists
    assign pready  = acc_wait_r;
    assign prdata  = rdata_r;
    assign pslverr = acc_wait_r && err_r;
    assign irq     = |(ist_r & imask_r);

    assign read_chunk_disable        = fctl_r[`DFC_BIT_RD_CHUNK_DIS];
    assign strict_cache_assoc        = fctl_r[`DFC_BIT_STRICT_ASSOC];
    assign clock_run                 = fctl_r[`DFC_CGO_MSB:0];
    assign cache_utilization_control = util_r;
    assign mgr_cache_attr = fctl_r[`DFC_BIT_NO_CACHE_CORR] ?
                            `DFC_CACHE_IDX : `DFC_CACHE_CORRECTED;

    // Residency may go ahead only when each enabled wait is satisfied
    assign res_proceed = (!fctl_r[`DFC_BIT_RES_WAIT_CMD] || res_cmd_done) &&
                         (!fctl_r[`DFC_BIT_RES_WAIT_SEARCH] || pt_search_done);

    // ==========================================================
    // Checks
    property p_ns_no_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && pprot[1] && paddr == `DFC_OFF_FUNC_CTRL) |=> $stable(fctl_r);
    endproperty
    a_ns_no_write: assert property (p_ns_no_write)
        else $error("Non-secure write changed control");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (fctl_r & ~`DFC_FCTL_WMASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved control bit set");

    property p_util_any;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `DFC_OFF_UTIL && pstrb == 4'hf)
            |=> cache_utilization_control == $past(pwdata);
    endproperty
    a_util_any: assert property (p_util_any)
        else $error("Utilization write lost");

    property p_assoc;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && secure && paddr == `DFC_OFF_FUNC_CTRL && pstrb[3])
            |=> strict_cache_assoc == $past(pwdata[`DFC_BIT_STRICT_ASSOC]);
    endproperty
    a_assoc: assert property (p_assoc)
        else $error("Associativity output wrong");

    property p_cache_attr;
        @(posedge pclk) disable iff (!presetn)
        fctl_r[`DFC_BIT_NO_CACHE_CORR] |-> mgr_cache_attr == `DFC_CACHE_IDX;
    endproperty
    a_cache_attr: assert property (p_cache_attr)
        else $error("Cache attribute not modified");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        ##1 clock_run == $past(fctl_nxt[`DFC_CGO_MSB:0]);
    endproperty
    a_gate: assert property (p_gate)
        else $error("Clock override not following register");

    property p_res_wait;
        @(posedge pclk) disable iff (!presetn)
        (fctl_r[`DFC_BIT_RES_WAIT_CMD] && !res_cmd_done) |-> !res_proceed;
    endproperty
    a_res_wait: assert property (p_res_wait)
        else $error("Residency did not wait on command");

    property p_res_search;
        @(posedge pclk) disable iff (!presetn)
        (fctl_r[`DFC_BIT_RES_WAIT_SEARCH] && !pt_search_done) |-> !res_proceed;
    endproperty
    a_res_search: assert property (p_res_search)
        else $error("Residency did not wait on search");

    property p_pready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("Ready held longer than one cycle");

    property p_ns_read_zero;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !acc_wait_r && !pwrite && pprot[1] && paddr == `DFC_OFF_FUNC_CTRL)
            |=> prdata == 32'h00000000;
    endproperty
    a_ns_read_zero: assert property (p_ns_read_zero)
        else $error("Non-secure read exposed control");

    property p_event_sticks;
        @(posedge pclk) disable iff (!presetn)
        rd_evt |=> ist_r[`DFC_IRQ_RD_POISON];
    endproperty
    a_event_sticks: assert property (p_event_sticks)
        else $error("Read poison event lost");

    property p_clear_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == `DFC_OFF_IRQ_STATUS && !rd_evt && !wr_evt && !deny_evt)
            |=> (ist_r & $past(rdata_r[`DFC_IRQ_W-1:0])) == '0;
    endproperty
    a_clear_read: assert property (p_clear_read)
        else $error("Status bits not cleared by read");
endmodule // dfc_top
`default_nettype wire

// *** test/tb_distributor_function_control.sv ***
// Purpose: Self-checking bench for the function-control register bank
// Assumes: One APB wait state; poison pulses one cycle after their cause
// Notes:   Fixed stimulus only; pready, prdata, pslverr and outputs checked just after an apb call are sampled at the rising edge, others on the falling edge
`include "dfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_distributor_function_control
    import dfc_pkg::*;
;
    // ==========================================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, util, rd;
    logic [3:0]  pstrb, attr;
    logic [2:0]  pprot;
    logic        ram_v, ram_c, sub_v, sub_p, mgr_v, mgr_p, rd_flag, wr_rej, mgr_err;
    logic        qreq_n, idle, qaccept_n, power_request_refuse, qactive, cmd_done, srch_done, proceed;
    logic        chunk_dis, strict, er;
    logic [10:0] clock_run;
    int          fails, cmp_count;

    dfc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .ram_rd_valid(ram_v), .ram_rd_corrupt(ram_c), .sub_wr_valid(sub_v),
        .sub_wr_poison(sub_p), .mgr_rd_valid(mgr_v), .mgr_rd_poison(mgr_p),
        .read_poison_flag(rd_flag), .sub_wr_reject(wr_rej), .mgr_rd_error(mgr_err),
        .qreq_n(qreq_n), .block_idle(idle), .qaccept_n(qaccept_n), .power_request_refuse(power_request_refuse),
        .qactive(qactive), .res_cmd_done(cmd_done), .pt_search_done(srch_done),
        .res_proceed(proceed), .read_chunk_disable(chunk_dis),
        .strict_cache_assoc(strict), .mgr_cache_attr(attr), .clock_run(clock_run),
        .cache_utilization_control(util));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [2:0] p);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pprot   <= p;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("ERROR %0t: no pready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input int path, input logic exp);
        @(posedge pclk);
        case (path)
            0: begin ram_v <= 1'b1; ram_c <= 1'b1; end
            1: begin sub_v <= 1'b1; sub_p <= 1'b1; end
            default: begin mgr_v <= 1'b1; mgr_p <= 1'b1; end
        endcase
        @(posedge pclk);
        {ram_v, ram_c, sub_v, sub_p, mgr_v, mgr_p} <= 6'h00;
        @(negedge pclk);
        chk({31'h0, (path == 0) ? rd_flag : (path == 1) ? wr_rej : mgr_err},
            {31'h0, exp}, "poison output");
    endtask

    task automatic wait_q(input logic dn, input logic an);
        int n;
        n = 0;
        while ((power_request_refuse !== dn || qaccept_n !== an) && n < 12) begin
            @(negedge pclk);
            n++;
        end
        chk({30'h0, power_request_refuse, qaccept_n}, {30'h0, dn, an}, "q-channel");
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Whole run is well under a thousand cycles
    initial begin
        #(50 * 4000);
        fails++;
        $display("ERROR %0t: timeout", $time);
        final_report();
    end

    // ==========================================================
    // Tests
    initial begin
        fails = 0;
        cmp_count = 0;
        {presetn, psel, penable, pwrite, ram_v, ram_c, sub_v, sub_p, mgr_v, mgr_p} = '0;
        {cmd_done, srch_done} = 2'b00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hf;
        pprot = 3'h0;
        qreq_n = 1'b1;
        idle = 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk({17'h0, attr, clock_run}, {17'h0, `DFC_CACHE_CORRECTED, 11'h000}, "reset outs");
        chk({30'h0, irq, qaccept_n}, 32'h1, "reset irq/q");
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DFC_OFF_FUNC_CTRL, 32'h0, 3'h0);
        chk(rd, `DFC_FCTL_RESET, "fctl reset");
        apb(1'b0, `DFC_OFF_UTIL, 32'h0, 3'h0);
        chk(rd, `DFC_UTIL_RESET, "util reset");
        // Reserved bits must drop away on read back
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'hffffffff, 3'h0);
        apb(1'b0, `DFC_OFF_FUNC_CTRL, 32'h0, 3'h0);
        chk(rd, 32'hf20f07ff, "fctl all ones");
        chk({31'h0, chunk_dis}, 32'h1, "chunk disable");
        chk({31'h0, strict}, 32'h1, "strict assoc");
        chk({28'h0, attr}, {28'h0, `DFC_CACHE_IDX}, "cache attr");
        chk({21'h0, clock_run}, 32'h7ff, "clock run");
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h0, 3'h2);
        chk({31'h0, er}, 32'h1, "ns write err");
        apb(1'b0, `DFC_OFF_FUNC_CTRL, 32'h0, 3'h2);
        chk(rd, 32'h0, "ns read");
        apb(1'b0, `DFC_OFF_FUNC_CTRL, 32'h0, 3'h0);
        chk(rd, 32'hf20f07ff, "ns write kept out");
        apb(1'b1, `DFC_OFF_UTIL, 32'ha5c35a3c, 3'h2);
        apb(1'b0, `DFC_OFF_UTIL, 32'h0, 3'h2);
        chk(rd, 32'ha5c35a3c, "util ns access");
        chk(util, 32'ha5c35a3c, "util output");
        // Only the enabled bytes may change
        pstrb <= 4'h3;
        apb(1'b1, `DFC_OFF_UTIL, 32'hffffffff, 3'h0);
        pstrb <= 4'hf;
        @(negedge pclk);
        chk(util, 32'ha5c3ffff, "util strobes");
        apb(1'b0, 12'h020, 32'h0, 3'h0);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
        // Each override bit drives its own gate only
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h1 << i, 3'h0);
            @(negedge pclk);
            chk({21'h0, clock_run}, 32'h1 << i, "gate walk");
        end
        chk({31'h0, chunk_dis}, 32'h0, "chunk enabled");
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h00080000, 3'h0);
        @(negedge pclk);
        chk({31'h0, proceed}, 32'h0, "wait on command");
        @(posedge pclk);
        cmd_done <= 1'b1;
        @(negedge pclk);
        chk({31'h0, proceed}, 32'h1, "command done");
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h00010000, 3'h0);
        cmd_done <= 1'b0;
        @(negedge pclk);
        chk({31'h0, proceed}, 32'h0, "wait on search");
        @(posedge pclk);
        srch_done <= 1'b1;
        @(negedge pclk);
        chk({31'h0, proceed}, 32'h1, "search done");
        // Events, sticky status and clear on read
        apb(1'b1, `DFC_OFF_IRQ_MASK, 32'h7, 3'h0);
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'hc0000000, 3'h0);
        pulse(0, 1'b1);
        pulse(1, 1'b1);
        pulse(2, 1'b1);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b0, `DFC_OFF_IRQ_STATUS, 32'h0, 3'h0);
        chk(rd, 32'h3, "status events");
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h20000000, 3'h0);
        pulse(0, 1'b0);
        pulse(1, 1'b0);
        pulse(2, 1'b0);
        apb(1'b1, `DFC_OFF_IRQ_MASK, 32'h0, 3'h0);
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h80000000, 3'h0);
        pulse(0, 1'b1);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b0, `DFC_OFF_IRQ_STATUS, 32'h0, 3'h0);
        chk(rd, 32'h1, "masked status");
        // Power-down refused while the refuse bit is set
        apb(1'b1, `DFC_OFF_IRQ_MASK, 32'h4, 3'h0);
        apb(1'b0, `DFC_OFF_IRQ_MASK, 32'h0, 3'h0);
        chk(rd, 32'h4, "mask readback");
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h00040000, 3'h0);
        qreq_n <= 1'b0;
        wait_q(1'b1, 1'b1);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1, "deny irq");
        @(posedge pclk);
        qreq_n <= 1'b1;
        wait_q(1'b0, 1'b1);
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h0, 3'h0);
        qreq_n <= 1'b0;
        wait_q(1'b0, 1'b0);
        apb(1'b0, `DFC_OFF_STATUS, 32'h0, 3'h0);
        chk(rd, 32'h3, "status accepted");
        @(posedge pclk);
        qreq_n <= 1'b1;
        wait_q(1'b0, 1'b1);
        // A busy block refuses power-down even with the refuse bit clear
        @(posedge pclk);
        idle   <= 1'b0;
        qreq_n <= 1'b0;
        wait_q(1'b1, 1'b1);
        chk({31'h0, qactive}, 32'h1, "active while busy");
        @(posedge pclk);
        idle   <= 1'b1;
        qreq_n <= 1'b1;
        wait_q(1'b0, 1'b1);
        // Without gates every override stays set and the caches stay fully associative
        apb(1'b1, `DFC_OFF_FUNC_CTRL, 32'h000007ff, 3'h0);
        @(negedge pclk);
        chk({20'h0, strict, clock_run}, 32'h7ff, "gates held on");
        final_report();
    end
endmodule // tb_distributor_function_control
`default_nettype wire
